/* File: core/dmarc_pkg.sv */
/*
 Constants for the six-channel DMA reload, count, index and sync control block.
 Assumes a classic Wishbone slave with 32-bit data and byte addressing.
*/
package dmarc_pkg;
   localparam int NCH = 6;
   localparam int AW = 8;
   // Global register byte offsets.
   localparam logic [7:0] ADDR_PREC = 8'h00;
   localparam logic [7:0] ADDR_IDX0 = 8'h04;
   localparam logic [7:0] ADDR_IDX1 = 8'h08;
   localparam logic [7:0] ADDR_FRI0 = 8'h0C;
   localparam logic [7:0] ADDR_FRI1 = 8'h10;
   localparam logic [7:0] ADDR_STAT = 8'h14;
   // Per-channel register block: base + channel * stride + word * 4.
   localparam logic [7:0] ADDR_CH_BASE = 8'h40;
   localparam logic [7:0] CH_STRIDE = 8'h20;
   localparam logic [2:0] W_MODE = 3'h0;
   localparam logic [2:0] W_SYNC = 3'h1;
   localparam logic [2:0] W_SRC = 3'h2;
   localparam logic [2:0] W_DST = 3'h3;
   localparam logic [2:0] W_CTR = 3'h4;
   localparam logic [2:0] W_RSRC = 3'h5;
   localparam logic [2:0] W_RDST = 3'h6;
   localparam logic [2:0] W_RCNT = 3'h7;
   // Priority and enable control fields.
   localparam int PREC_FREE = 15;
   localparam int PREC_RSEL = 14;
   localparam int PREC_PRI_LSB = 8;
   localparam int PREC_MUX_LSB = 6;
   localparam int PREC_EN_LSB = 0;
   localparam logic [15:0] PREC_RESET = 16'h0000;
   // Transfer mode control fields.
   localparam int MODE_AUTO = 15;
   localparam int MODE_IEN = 14;
   localparam int MODE_INTERRUPT_MODE_BIT = 13;
   localparam int MODE_DWORD = 12;
   localparam int MODE_ABU = 11;
   localparam int MODE_SOURCE_INDEX_SELECT_LSB = 8;
   localparam int MODE_DESTINATION_INDEX_SELECT_LSB = 2;
   // Index select codes (3 bits).
   localparam logic [2:0] IDX_NONE = 3'h0;
   localparam logic [2:0] IDX_INC = 3'h1;
   localparam logic [2:0] IDX_DEC = 3'h2;
   localparam logic [2:0] IDX_SEL0 = 3'h3;
   localparam logic [2:0] IDX_SEL1 = 3'h4;
   // Sync event field in the sync/frame count register.
   localparam int SYNC_LSB = 12;
   localparam logic [3:0] SYNC_NONE = 4'h0;
   localparam logic [3:0] SYNC_UART = 4'h7;
   localparam logic [3:0] SYNC_RSV_LO = 4'h8;
   localparam logic [3:0] SYNC_RSV_HI = 4'hC;
   // Interrupt mux codes.
   localparam logic [1:0] MUX_SERIAL = 2'h0;
   localparam logic [1:0] MUX_CH23 = 2'h1;
   localparam logic [1:0] MUX_CH0123 = 2'h2;
endpackage

/* File: core/dmarc_addr_step.sv */
`timescale 1ns/1ps
/*
 Address adjustment for one side of a transfer.
 Assumes index values come from the global index registers.
*/
module dmarc_addr_step
   import dmarc_pkg::*;
(
   input wire logic [15:0] addr_i,
   input wire logic [2:0] sel_i,
   input wire logic last_i,
   input wire logic [15:0] eidx0_i,
   input wire logic [15:0] eidx1_i,
   input wire logic [15:0] fidx0_i,
   input wire logic [15:0] fidx1_i,
   output logic [15:0] addr_o
);
   always_comb begin
      unique case (sel_i)
         IDX_INC: addr_o = addr_i + 16'h0001;
         IDX_DEC: addr_o = addr_i - 16'h0001;
         // [RULE_10] element index add
         // [RULE_11] frame index at end
         IDX_SEL0: addr_o = addr_i + (last_i ? fidx0_i : eidx0_i);
         IDX_SEL1: addr_o = addr_i + (last_i ? fidx1_i : eidx1_i);
         default: addr_o = addr_i;
      endcase
   end
endmodule

/* File: core/dmarc_core.sv */
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
/*
 Six-channel DMA control: reload, element and frame counting, doubleword
 pairing, address indexing, interrupt modes, sync event selection and the
 CPU interrupt multiplexer.
 Assumes a classic Wishbone master, event inputs already on clk_i, and a
 memory-side engine that pulses rd_done_i per completed read half.
*/
//
// Operation
// [RULE_01] With auto-reinit, working registers reload after each block.
// [RULE_02] Software may rewrite reload registers anytime; used at next reload.
// [RULE_03] Reload select 0 uses channel 0 set; 1 uses each own set.
// [RULE_04] Reload select is bit 14, free-run bit 15 of control register.
// [RULE_05] Eight-bit frame counter, 0 means one frame, decrements per frame.
// [RULE_06] After final frame with auto-reinit, frame counter reloads globally.
// [RULE_07] Sixteen-bit element counter decrements per element; FFFF means 65536.
// [RULE_08] With auto-reinit, element counter reloads after final frame.
// [RULE_09] Doubleword: two 16-bit halves, addresses step each, one element.
// [RULE_10] Non-last transfers add selected element index to address.
// [RULE_11] Last transfer of a frame adds selected frame index instead.
// [RULE_12] Interrupt enable 0 means no channel interrupt at all.
// [RULE_13] Autobuffer: full buffer only, or half and full with mode bit.
// [RULE_14] Multi-frame: block end only, or also every frame end.
// [RULE_15] Four-bit sync field selects none, serial, UART, timers, external.
// [RULE_16] UART event paces transfers only; no UART data movement.
// [RULE_17] Each channel has an interrupt; channels 0-3 share serial lines.
// [RULE_18] Mux select routes CPU positions 6, 7, 10, 11 by code.
// [RULE_19] Reset returns mux select to 00, serial interrupts routed.
// [RULE_20] Control register: free 15, reload 14, prio 13-8, mux 7-6, en 5-0.
// [RULE_21] Mode register: auto-reinit 15, interrupt enable 14, mode 13.
// [RULE_22] Block end without auto-reinit clears enable and stops channel.
module dmarc_core
   import dmarc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [15:0] sync_events_i,
   input wire logic [3:0] serial_irq_i,
   input wire logic rd_done_i,
   output logic req_valid_o,
   output logic [2:0] req_chan_o,
   output logic [15:0] req_src_o,
   output logic [15:0] req_dst_o,
   output logic [NCH-1:0] chan_irq_o,
   output logic [3:0] cpu_irq_o,
   output logic free_run_o,
   output logic [NCH-1:0] chan_prio_o
);
   logic [15:0] prec;
   logic [15:0] eidx0, eidx1, fidx0, fidx1;
   logic [15:0] mode [NCH];
   logic [15:0] sefc [NCH];
   logic [15:0] src [NCH];
   logic [15:0] dst [NCH];
   logic [15:0] ctr [NCH];
   logic [15:0] rsrc [NCH];
   logic [15:0] rdst [NCH];
   logic [15:0] rcnt [NCH];
   logic [7:0] rfrm [NCH];
   logic [15:0] bsize [NCH];
   logic [15:0] bcount [NCH];
   logic [NCH-1:0] pend;
   logic [NCH-1:0] hi_half;
   logic [NCH-1:0] half_done;
   logic [2:0] cur;
   logic busy;
   logic [NCH-1:0] irq_pulse;

   logic wb_req, wb_wr;
   logic [2:0] a_ch, a_w;
   logic a_chan_hit;
   logic [15:0] wdat;

   // Decodes a channel-block address into its channel number.
   function automatic logic [2:0] ch_of(input logic [AW-1:0] a);
      logic [7:0] off;
      off = a - ADDR_CH_BASE;
      return off[7:5];
   endfunction

   // Sync event selected by a channel's field; UART only paces.
   function automatic logic sync_ok(input logic [3:0] code, input logic [15:0] ev);
      // [RULE_15] sync event decode
      // [RULE_16] UART pacing only
      if (code == SYNC_NONE)
         return 1'b1;
      if (code >= SYNC_RSV_LO && code <= SYNC_RSV_HI)
         return 1'b0;
      return ev[code];
   endfunction

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr = wb_req && wb_we_i;
   assign a_ch = ch_of(wb_adr_i);
   assign a_w = wb_adr_i[4:2];
   assign a_chan_hit = wb_adr_i >= ADDR_CH_BASE && a_ch < 3'(NCH);
   assign wdat = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};

   always_ff @(posedge clk_i) begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_req;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_req && !wb_we_i) begin
         wb_dat_o <= 32'h0000_0000;
         if (a_chan_hit) begin
            unique case (a_w)
               W_MODE: wb_dat_o[15:0] <= mode[a_ch];
               W_SYNC: wb_dat_o[15:0] <= sefc[a_ch];
               W_SRC: wb_dat_o[15:0] <= src[a_ch];
               W_DST: wb_dat_o[15:0] <= dst[a_ch];
               W_CTR: wb_dat_o[15:0] <= ctr[a_ch];
               W_RSRC: wb_dat_o[15:0] <= rsrc[a_ch];
               W_RDST: wb_dat_o[15:0] <= rdst[a_ch];
               W_RCNT: wb_dat_o <= {8'h00, rfrm[a_ch], rcnt[a_ch]};
            endcase
         end else begin
            unique case (wb_adr_i)
               ADDR_PREC: wb_dat_o[15:0] <= prec;
               ADDR_IDX0: wb_dat_o[15:0] <= eidx0;
               ADDR_IDX1: wb_dat_o[15:0] <= eidx1;
               ADDR_FRI0: wb_dat_o[15:0] <= fidx0;
               ADDR_FRI1: wb_dat_o[15:0] <= fidx1;
               ADDR_STAT: wb_dat_o <= {16'h0000, 2'b00, hi_half, 2'b00, pend};
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Global index registers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         eidx0 <= 16'h0000;
         eidx1 <= 16'h0000;
         fidx0 <= 16'h0000;
         fidx1 <= 16'h0000;
      end else if (wb_wr && !a_chan_hit) begin
         if (wb_adr_i == ADDR_IDX0) eidx0 <= wdat;
         if (wb_adr_i == ADDR_IDX1) eidx1 <= wdat;
         if (wb_adr_i == ADDR_FRI0) fidx0 <= wdat;
         if (wb_adr_i == ADDR_FRI1) fidx1 <= wdat;
      end
   end

   // Reload registers and mode registers, software only.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NCH; i++) begin
            mode[i] <= 16'h0000;
            rsrc[i] <= 16'h0000;
            rdst[i] <= 16'h0000;
            rcnt[i] <= 16'h0000;
            rfrm[i] <= 8'h00;
         end
      end else if (wb_wr && a_chan_hit) begin
         // [RULE_02] reload rewrite anytime
         unique case (a_w)
            W_MODE: mode[a_ch] <= wdat;
            W_RSRC: rsrc[a_ch] <= wdat;
            W_RDST: rdst[a_ch] <= wdat;
            W_RCNT: begin
               rcnt[a_ch] <= wdat;
               if (wb_sel_i[2]) rfrm[a_ch] <= wb_dat_i[23:16];
            end
            default: ;
         endcase
      end
   end

   // Transfer issue: one outstanding read half at a time.
   logic [NCH-1:0] ready;
   logic [2:0] pick;
   logic pick_ok;
   always_comb begin
      pick = 3'h0;
      pick_ok = 1'b0;
      for (int i = NCH - 1; i >= 0; i--) begin
         ready[i] = prec[PREC_EN_LSB + i] && (hi_half[i] || sync_ok(sefc[i][SYNC_LSB +: 4],
            sync_events_i));
         if (ready[i]) begin
            pick = 3'(i);
            pick_ok = 1'b1;
         end
      end
   end

   logic cur_last, cur_dw, cur_end_elem, cur_blk_end, cur_rsel;
   logic [15:0] next_src, next_dst;
   logic [2:0] rs;
   assign cur_dw = mode[cur][MODE_DWORD];
   // [RULE_09] pair counts as one element
   assign cur_end_elem = !cur_dw || hi_half[cur];
   assign cur_last = cur_end_elem && ctr[cur] == 16'h0000;
   assign cur_blk_end = cur_last && sefc[cur][7:0] == 8'h00;
   assign cur_rsel = prec[PREC_RSEL];
   // [RULE_03] reload set select
   assign rs = cur_rsel ? cur : 3'h0;

   dmarc_addr_step u_src (
      .addr_i(src[cur]), .sel_i(mode[cur][MODE_SOURCE_INDEX_SELECT_LSB +: 3]), .last_i(cur_last),
      .eidx0_i(eidx0), .eidx1_i(eidx1), .fidx0_i(fidx0), .fidx1_i(fidx1),
      .addr_o(next_src)
   );
   dmarc_addr_step u_dst (
      .addr_i(dst[cur]), .sel_i(mode[cur][MODE_DESTINATION_INDEX_SELECT_LSB +: 3]), .last_i(cur_last),
      .eidx0_i(eidx0), .eidx1_i(eidx1), .fidx0_i(fidx0), .fidx1_i(fidx1),
      .addr_o(next_dst)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy <= 1'b0;
         cur <= 3'h0;
         req_valid_o <= 1'b0;
         req_chan_o <= 3'h0;
         req_src_o <= 16'h0000;
         req_dst_o <= 16'h0000;
      end else if (!busy) begin
         if (pick_ok) begin
            busy <= 1'b1;
            cur <= pick;
            req_valid_o <= 1'b1;
            req_chan_o <= pick;
            req_src_o <= src[pick];
            req_dst_o <= dst[pick];
         end
      end else begin
         req_valid_o <= 1'b0;
         if (rd_done_i)
            busy <= 1'b0;
      end
   end

   // Working registers: software writes, then the transfer engine updates.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NCH; i++) begin
            src[i] <= 16'h0000;
            dst[i] <= 16'h0000;
            ctr[i] <= 16'h0000;
            sefc[i] <= 16'h0000;
            bsize[i] <= 16'h0000;
            bcount[i] <= 16'h0000;
            hi_half[i] <= 1'b0;
            half_done[i] <= 1'b0;
         end
      end else begin
         if (wb_wr && a_chan_hit) begin
            unique case (a_w)
               W_SRC: src[a_ch] <= wdat;
               W_DST: dst[a_ch] <= wdat;
               W_CTR: begin
                  ctr[a_ch] <= wdat;
                  bsize[a_ch] <= wdat;
                  bcount[a_ch] <= 16'h0000;
                  half_done[a_ch] <= 1'b0;
               end
               W_SYNC: sefc[a_ch] <= wdat;
               default: ;
            endcase
         end
         if (busy && rd_done_i) begin
            src[cur] <= next_src;
            dst[cur] <= next_dst;
            hi_half[cur] <= cur_dw && !hi_half[cur];
            if (cur_end_elem) begin
               // [RULE_07] element count down
               ctr[cur] <= ctr[cur] - 16'h0001;
               bcount[cur] <= bcount[cur] + 16'h0001;
               if (bcount[cur] == {1'b0, bsize[cur][15:1]})
                  half_done[cur] <= 1'b1;
            end
            if (cur_last) begin
               // [RULE_05] frame count down
               sefc[cur][7:0] <= sefc[cur][7:0] - 8'h01;
               ctr[cur] <= bsize[cur];
               bcount[cur] <= 16'h0000;
            end
            if (cur_blk_end) begin
               half_done[cur] <= 1'b0;
               if (mode[cur][MODE_AUTO]) begin
                  // [RULE_01] auto_reinit_enable reload
                  src[cur] <= rsrc[rs];
                  dst[cur] <= rdst[rs];
                  // [RULE_08] element reload
                  ctr[cur] <= rcnt[rs];
                  bsize[cur] <= rcnt[rs];
                  // [RULE_06] frame reload
                  sefc[cur][7:0] <= rfrm[rs];
               end
            end
         end
      end
   end

   // Control register; hardware clear of enable at block end wins over writes.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // [RULE_19] mux reset to 00
         prec <= PREC_RESET;
      end else begin
         if (wb_wr && !a_chan_hit && wb_adr_i == ADDR_PREC) begin
            // [RULE_04] reload select bit 14
            // [RULE_20] control field layout
            prec <= wdat;
         end
         if (busy && rd_done_i && cur_blk_end && !mode[cur][MODE_AUTO]) begin
            // [RULE_22] stop without auto_reinit_enable
            prec[PREC_EN_LSB + cur] <= 1'b0;
         end
      end
   end

   // Interrupt events per channel.
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         irq_pulse[i] = 1'b0;
         // [RULE_21] mode bit positions
         if (busy && rd_done_i && cur == 3'(i) && mode[i][MODE_IEN]) begin
            if (mode[i][MODE_ABU]) begin
               // [RULE_13] autobuffer half and full
               irq_pulse[i] = cur_blk_end || (mode[i][MODE_INTERRUPT_MODE_BIT] && cur_end_elem
                  && !half_done[i] && bcount[i] == {1'b0, bsize[i][15:1]});
            end else begin
               // [RULE_14] frame and block end
               irq_pulse[i] = cur_blk_end || (mode[i][MODE_INTERRUPT_MODE_BIT] && cur_last);
            end
         end
         // [RULE_12] disabled means none
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         pend <= '0;
      else
         pend <= irq_pulse;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chan_irq_o <= '0;
         cpu_irq_o <= 4'h0;
         free_run_o <= 1'b0;
         chan_prio_o <= '0;
      end else begin
         // [RULE_17] per-channel interrupts
         chan_irq_o <= irq_pulse;
         free_run_o <= prec[PREC_FREE];
         chan_prio_o <= prec[PREC_PRI_LSB +: NCH];
         // [RULE_18] interrupt mux routing
         unique case (prec[PREC_MUX_LSB +: 2])
            MUX_CH23: cpu_irq_o <= {irq_pulse[3:2], serial_irq_i[1:0]};
            MUX_CH0123: cpu_irq_o <= irq_pulse[3:0];
            default: cpu_irq_o <= serial_irq_i;
         endcase
      end
   end
endmodule

/* File: tb/dmarc_chk_assertions.sv */
`timescale 1ns/1ps
/* Port checker for the DMA control block, bound to dmarc_core.
   Assumes register writes set all byte lanes. */
module dmarc_chk
   import dmarc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [AW-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic [3:0] serial_irq_i,
   input wire logic req_valid_o,
   input wire logic [NCH-1:0] chan_irq_o,
   input wire logic [3:0] cpu_irq_o,
   input wire logic free_run_o,
   input wire logic [NCH-1:0] chan_prio_o
);
   logic [15:0] prec;
   logic [NCH-1:0] ien;
   logic [1:0] mux;
   assign mux = prec[PREC_MUX_LSB +: 2];
   // Shadows of control bits, taken at each acknowledged write.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prec <= PREC_RESET;
         ien <= '0;
      end else if (wb_ack_o && wb_we_i) begin
         if (wb_adr_i == ADDR_PREC) begin
            prec <= wb_dat_i[15:0];
         end
         for (int n = 0; n < NCH; n++) begin
            if (wb_adr_i == ADDR_CH_BASE + CH_STRIDE * 8'(n)) begin
               ien[n] <= wb_dat_i[MODE_IEN];
            end
         end
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   property p_ack;
      s_req |=> s_ack;
   endproperty
   a_ack: assert property (p_ack) else $error("ack timing wrong");
   property p_mux_serial;
      mux == MUX_SERIAL |=> cpu_irq_o == $past(serial_irq_i);
   endproperty
   a_mux_serial: assert property (p_mux_serial) else $error("serial route wrong");
   property p_mux_ch23;
      mux == MUX_CH23 |=> cpu_irq_o[1:0] == $past(serial_irq_i[1:0]);
   endproperty
   a_mux_ch23: assert property (p_mux_ch23) else $error("mixed route wrong");
   property p_mux_dma;
      mux == MUX_CH0123 |=> (cpu_irq_o & ~(chan_irq_o[3:0] | $past(chan_irq_o[3:0]))) == 4'h0;
   endproperty
   a_mux_dma: assert property (p_mux_dma) else $error("channel route wrong");
   property p_ien;
      (chan_irq_o & ~ien) == '0;
   endproperty
   a_ien: assert property (p_ien) else $error("irq while disabled");
   property p_copy;
      $stable(prec) |-> free_run_o == prec[PREC_FREE] && chan_prio_o == prec[PREC_PRI_LSB +: NCH];
   endproperty
   a_copy: assert property (p_copy) else $error("control copy wrong");
   property p_req;
      req_valid_o |=> !req_valid_o;
   endproperty
   a_req: assert property (p_req) else $error("issue not a pulse");
   property p_idle;
      prec[NCH-1:0] == '0 |-> !req_valid_o;
   endproperty
   a_idle: assert property (p_idle) else $error("issue while disabled");
endmodule
bind dmarc_core dmarc_chk dmarc_chk_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .serial_irq_i(serial_irq_i), .req_valid_o(req_valid_o),
   .chan_irq_o(chan_irq_o), .cpu_irq_o(cpu_irq_o), .free_run_o(free_run_o),
   .chan_prio_o(chan_prio_o));

/* File: tb/dmarc_far_model.sv */
`timescale 1ns/1ps
/* Memory-side engine model: answers each issued read half.
   Assumes req_valid_i is a one-cycle pulse on clk_i. */
module dmarc_far_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req_valid_i,
   input wire logic slow_i,
   output logic rd_done_o
);
   logic [2:0] cnt;
   logic busy;
   always_ff @(posedge clk_i) begin
      rd_done_o <= 1'b0;
      if (rst_i) begin
         busy <= 1'b0;
         cnt <= 3'h0;
      end else if (req_valid_i) begin
         busy <= 1'b1;
         cnt <= slow_i ? 3'h4 : 3'h0;
      end else if (busy) begin
         busy <= cnt != 3'h0;
         rd_done_o <= cnt == 3'h0;
         cnt <= cnt - 3'h1;
      end
   end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
/* Bench for the DMA control block over Wishbone.
   Assumes the memory model answers every issued half. */
module tb_top;
   import dmarc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [AW-1:0] wb_adr = '0;
   logic [3:0] wb_sel = 4'hF;
   logic [31:0] wb_wdat = '0;
   logic [31:0] wb_rdat, rd_val;
   logic wb_ack, rd_done, req_valid, free_run;
   logic [15:0] sync_ev = '0;
   logic [3:0] ser_irq = '0;
   logic slow = 1'b0;
   logic [15:0] req_src, req_dst;
   logic [NCH-1:0] chan_irq, chan_prio;
   logic [3:0] cpu_irq;
   logic [2:0] req_chan;
   logic [15:0] q_src[$], q_dst[$];
   int n_fail = 0, checks = 0, cycles = 0, irq0 = 0, cpu0 = 0, cpu_base = 0;
   logic [31:0] mux_exp [3] = '{32'hF, 32'h3, 32'h0};
   logic [3:0] codes [4] = '{4'h7, 4'h9, 4'hD, 4'hE};
   int hits [4] = '{1, 0, 1, 1};
   dmarc_core dmarc_core_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .sync_events_i(sync_ev), .serial_irq_i(ser_irq),
      .rd_done_i(rd_done), .req_valid_o(req_valid), .req_chan_o(req_chan), .req_src_o(req_src),
      .req_dst_o(req_dst), .chan_irq_o(chan_irq), .cpu_irq_o(cpu_irq),
      .free_run_o(free_run), .chan_prio_o(chan_prio));
   dmarc_far_model dmarc_far_model_i (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid),
      .slow_i(slow), .rd_done_o(rd_done));
   always #12.5 clk_i = ~clk_i;
   task automatic report_and_stop();
      if (n_fail == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic [AW-1:0] a, input logic w, input logic [31:0] d);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_wdat <= d;
      do @(posedge clk_i); while (wb_ack !== 1'b1);
      rd_val = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
      wb(a, 1'b1, d);
   endtask
   task automatic rd_chk(input logic [AW-1:0] a, input logic [31:0] e);
      wb(a, 1'b0, 32'h0);
      chk(rd_val, e);
   endtask
   function automatic logic [7:0] ca(input int ch, input logic [2:0] w);
      return ADDR_CH_BASE + CH_STRIDE * 8'(ch) + {3'h0, w, 2'h0};
   endfunction
   task automatic setup(input int ch, input logic [15:0] mode, s, d, n, fs);
      q_src.delete();
      q_dst.delete();
      wr(ca(ch, W_MODE), {16'h0, mode});
      wr(ca(ch, W_SRC), {16'h0, s});
      wr(ca(ch, W_DST), {16'h0, d});
      wr(ca(ch, W_CTR), {16'h0, n});
      wr(ca(ch, W_SYNC), {16'h0, fs});
   endtask
   task automatic run_to_end(input logic [31:0] p);
      wr(ADDR_PREC, p);
      do wb(ADDR_PREC, 1'b0, 32'h0); while (rd_val[NCH-1:0] !== '0);
      chk(rd_val, p & 32'hFFC0);
   endtask
   task automatic q_chk(input logic [15:0] s, input logic [15:0] d);
      logic [15:0] gs, gd;
      gs = 16'hXXXX;
      gd = 16'hXXXX;
      if (q_src.size() > 0) begin
         gs = q_src.pop_front();
         gd = q_dst.pop_front();
      end
      chk({gs, gd}, {s, d});
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (req_valid === 1'b1) begin
         q_src.push_back(req_src);
         q_dst.push_back(req_dst);
      end
      if (chan_irq[0] === 1'b1) irq0++;
      if (cpu_irq[0] === 1'b1) cpu0++;
      if (cycles == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd_chk(ADDR_PREC, 32'h0);
      wr(ADDR_PREC, 32'hFFC0);
      rd_chk(ADDR_PREC, 32'hFFC0);
      chk({25'h0, free_run, chan_prio}, 32'h7F);
      rd_chk(8'h18, 32'h0);
      for (int m = 0; m < 3; m++) begin
         wr(ADDR_PREC, 32'(m) << 6);
         ser_irq <= 4'hF;
         repeat (3) @(posedge clk_i);
         chk({28'h0, cpu_irq}, mux_exp[m]);
         ser_irq <= 4'h0;
      end
      wr(ADDR_IDX0, 32'h2);
      wr(ADDR_FRI0, 32'h10);
      setup(0, 16'h6304, 16'h100, 16'h200, 16'h1, 16'h1);
      // Serial pulses from the routing checks above are already counted.
      cpu_base = cpu0;
      run_to_end(32'h81);
      q_chk(16'h100, 16'h200);
      q_chk(16'h102, 16'h201);
      q_chk(16'h112, 16'h202);
      q_chk(16'h114, 16'h203);
      chk(32'(q_src.size()), 32'h0);
      chk(32'(irq0), 32'h2);
      chk(32'(cpu0 - cpu_base), 32'h2);
      setup(0, 16'h1104, 16'h100, 16'h200, 16'h0, 16'h0);
      run_to_end(32'h81);
      q_chk(16'h100, 16'h200);
      q_chk(16'h101, 16'h201);
      chk(32'(q_src.size()), 32'h0);
      chk(32'(irq0), 32'h2);
      // Autobuffer with half-buffer interrupts: four elements, two interrupts.
      setup(0, 16'h6900, 16'h100, 16'h200, 16'h3, 16'h0);
      run_to_end(32'h1);
      chk(32'(q_src.size()), 32'h4);
      chk(32'(irq0), 32'h4);
      slow <= 1'b1;
      for (int r = 0; r < 2; r++) begin
         setup(1, 16'h8100, 16'h300, 16'h400, 16'h1, 16'h0);
         wr(ADDR_PREC, (32'(r) << PREC_RSEL) | 32'h2);
         // Reload values are written only after the block has started.
         wr(ca(r, W_RSRC), r ? 32'h500 : 32'h700);
         wr(ca(r, W_RDST), r ? 32'h600 : 32'h800);
         wr(ca(r, W_RCNT), 32'h10000);
         while (q_src.size() < 4) @(posedge clk_i);
         wr(ADDR_PREC, 32'h0);
         repeat (10) @(posedge clk_i);
         q_chk(16'h300, 16'h400);
         q_chk(16'h301, 16'h400);
         q_chk(r ? 16'h500 : 16'h700, r ? 16'h600 : 16'h800);
         q_chk(r ? 16'h501 : 16'h701, r ? 16'h600 : 16'h800);
      end
      slow <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         setup(2, 16'h0100, 16'h900, 16'hA00, 16'h0, {codes[k], 12'h0});
         wr(ADDR_PREC, 32'h4);
         repeat (5) @(posedge clk_i);
         chk(32'(q_src.size()), 32'h0);
         sync_ev[codes[k]] <= 1'b1;
         @(posedge clk_i);
         sync_ev <= '0;
         repeat (10) @(posedge clk_i);
         chk(32'(q_src.size()), 32'(hits[k]));
         chk(32'(req_chan), 32'h2);
         wr(ADDR_PREC, 32'h0);
      end
      report_and_stop();
   end
endmodule
